// ==== verilog/cpoc_consts.svh ====
// Offsets, field positions, reset values and timing constants of the converter control block
`ifndef CPOC_CONSTS_SVH
`define CPOC_CONSTS_SVH

`define CPOC_CLK_HZ 50000000
`define CPOC_CYC_PER_MS 50000
`define CPOC_CYC_PER_US 50

// Times in their own units
`define CPOC_LL_STEP_MS 10000
`define CPOC_RETRY_MS 3000
`define CPOC_OV_MS 100
`define CPOC_SOFT_US 1000
`define CPOC_RAMP_US 1

// Register offsets
`define CPOC_OFS_LL_CTRL 8'h0E
`define CPOC_OFS_OUTPUT_VOLTAGE_TARGET_LO 8'h10
`define CPOC_OFS_OUTPUT_VOLTAGE_TARGET_HI 8'h11
`define CPOC_OFS_CONV_CTRL 8'h12
`define CPOC_OFS_STATUS 8'h20

// Field positions
`define CPOC_LL_EN_BIT 0
`define CPOC_LL_DLY_LSB 1
`define CPOC_OVDIS_BIT 3
`define CPOC_DNDIS_BIT 4
`define CPOC_RAMP_LSB 3
`define CPOC_CONV_EN_BIT 0
`define CPOC_FSW_LSB 3

// Reset values
`define CPOC_RST_LL_CTRL 8'h00
`define CPOC_RST_OUTPUT_VOLTAGE_TARGET 11'h1F4
`define CPOC_RST_RAMP 2'h0
`define CPOC_RST_CONV_EN 1'b1
`define CPOC_FSW_500K 2'h2

// Status codes
`define CPOC_CODE_RESTART 3'h0
`define CPOC_CODE_SOFT 3'h1
`define CPOC_CODE_STEADY 3'h2
`define CPOC_CODE_RETRY 3'h3
`define CPOC_CODE_LLOFF 3'h4

`endif

// ==== verilog/cpoc_pkg.sv ====
// Types of the converter control block
package cpoc_pkg;

  typedef enum logic [4:0] {
    ST_RESTART = 5'b00001,
    ST_SOFT = 5'b00010,
    ST_STEADY = 5'b00100,
    ST_RETRY = 5'b01000,
    ST_LLOFF = 5'b10000
  } cpoc_state_type;

  typedef logic [10:0] cpoc_output_voltage_target_type;

endpackage

// ==== verilog/cpoc_top.sv ====
// Active conversion control: light-load shutdown, output stepping, discharge and state code
// Summary of operation
// - Light-load shutdown only in buck mode, headroom at least 0.5V, output below 6V.
// - Software arms light-load shutdown with its enable bit; clearing it disarms.
// - Output current under about 5mA counts as light load.
// - Light load declared only after low current outlasts the 10s, 20s or 30s delay.
// - On light load, enter shutdown state, switch output off, go to input idle.
// - Restart needs leaving and re-entering active mode by enable pin or register.
// - Output target may be rewritten any time; regulation follows the new value.
// - Setpoint ramps to a new target at the rate chosen by the ramp field.
// - Downward step with discharge enabled switches on the load until in regulation.
// - With overvoltage discharge enabled, pulldown is on during any overvoltage.
// - Three-bit state code: restart 0, soft 1, steady 2, retry 3, shutdown 4.
// - State code reads zero whenever the block is outside active mode.
// - Switching frequency is a fixed build choice, 500kHz default, not writable.
// - Output below 3V enters retry, holds output off 3s, then restarts.
// - Overvoltage stops switching at once; beyond 100ms it forces input idle.
`timescale 1ns/1ns
`default_nettype none
`include "cpoc_consts.svh"

module cpoc_top #(
  parameter int unsigned LL_STEP_CYC = `CPOC_LL_STEP_MS * `CPOC_CYC_PER_MS,
  parameter int unsigned RETRY_CYC = `CPOC_RETRY_MS * `CPOC_CYC_PER_MS,
  parameter int unsigned OV_CYC = `CPOC_OV_MS * `CPOC_CYC_PER_MS,
  parameter int unsigned SOFT_CYC = `CPOC_SOFT_US * `CPOC_CYC_PER_US,
  parameter logic [1:0] FSW_SEL = `CPOC_FSW_500K
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic en_pin,
  input wire logic buck_mode,
  input wire logic vin_headroom_ok,
  input wire logic output_voltage_target_below_6v,
  input wire logic iout_low,
  input wire logic output_voltage_target_below_3v,
  input wire logic output_voltage_target_overvoltage,
  input wire logic output_voltage_target_in_reg,
  output logic switch_en,
  output logic output_on,
  output logic input_idle_mode,
  output logic discharge_load_en,
  output logic ov_pulldown_en,
  output cpoc_pkg::cpoc_output_voltage_target_type output_voltage_target_setpoint,
  output logic [2:0] state_code
);
  import cpoc_pkg::*;

  localparam logic [9:0] RAMP_CYC = 10'(`CPOC_RAMP_US * `CPOC_CYC_PER_US);

  // Comparator and pin levels are asynchronous to clock
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  wire logic [7:0] pin_raw = {en_pin, buck_mode, vin_headroom_ok, output_voltage_target_below_6v,
                              iout_low, output_voltage_target_below_3v, output_voltage_target_overvoltage, output_voltage_target_in_reg};

  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end
    else
    begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end

  wire logic en_s = pin_sync[7];
  wire logic buck_s = pin_sync[6];
  wire logic headroom_s = pin_sync[5];
  wire logic below6_s = pin_sync[4];
  wire logic ilow_s = pin_sync[3];
  wire logic below3_s = pin_sync[2];
  wire logic ov_s = pin_sync[1];
  wire logic inreg_s = pin_sync[0];

  // Register file
  logic [7:0] ll_ctrl;
  cpoc_output_voltage_target_type output_voltage_target_target;
  logic [1:0] ramp_rate;
  logic conv_enable;

  wire logic wr_ll = reg_wr && reg_addr == `CPOC_OFS_LL_CTRL;
  wire logic wr_lo = reg_wr && reg_addr == `CPOC_OFS_OUTPUT_VOLTAGE_TARGET_LO;
  wire logic wr_hi = reg_wr && reg_addr == `CPOC_OFS_OUTPUT_VOLTAGE_TARGET_HI;
  wire logic wr_cv = reg_wr && reg_addr == `CPOC_OFS_CONV_CTRL;

  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      ll_ctrl <= `CPOC_RST_LL_CTRL;
      output_voltage_target_target <= `CPOC_RST_OUTPUT_VOLTAGE_TARGET;
      ramp_rate <= `CPOC_RST_RAMP;
      conv_enable <= `CPOC_RST_CONV_EN;
    end
    else
    begin
      if (wr_ll)
        ll_ctrl <= {3'h0, reg_wdata[4:0]};
      if (wr_lo)
        output_voltage_target_target[7:0] <= reg_wdata;
      if (wr_hi)
      begin
        output_voltage_target_target[10:8] <= reg_wdata[2:0];
        ramp_rate <= reg_wdata[`CPOC_RAMP_LSB+:2];
      end
      if (wr_cv)
        conv_enable <= reg_wdata[`CPOC_CONV_EN_BIT];
    end

  wire logic ll_en = ll_ctrl[`CPOC_LL_EN_BIT];
  wire logic [1:0] ll_dly = ll_ctrl[`CPOC_LL_DLY_LSB+:2];
  wire logic ovdis_en = ll_ctrl[`CPOC_OVDIS_BIT];
  wire logic dndis_en = ll_ctrl[`CPOC_DNDIS_BIT];

  // State machine and timers
  cpoc_state_type st;
  cpoc_state_type next_st;
  logic [31:0] tmr;
  logic [31:0] ll_cnt;
  logic [31:0] ov_cnt;
  logic ov_idle;

  // Leaving active mode (pin or register low) or entering overvoltage idle are the only ways out of shutdown
  wire logic active_req = en_s && conv_enable;
  wire logic active = active_req && !ov_idle;
  wire logic [31:0] ll_limit = (ll_dly == 2'h0) ? LL_STEP_CYC :
                               (ll_dly == 2'h1) ? 32'(2 * LL_STEP_CYC) :
                               32'(3 * LL_STEP_CYC);
  wire logic ll_window = buck_s && headroom_s && below6_s;
  wire logic ll_cond = ll_window && ll_en && ilow_s && st == ST_STEADY;
  wire logic ll_hit = ll_cond && ll_cnt >= ll_limit;
  wire logic ov_expire = ov_s && active && ov_cnt >= OV_CYC - 1;
  wire logic next_ov_idle = active_req && (ov_idle || ov_expire);

  always_comb
  begin
    next_st = st;
    if (!active)
      next_st = ST_RESTART;
    else
      unique case (st)
        ST_RESTART: next_st = ST_SOFT;
        ST_SOFT: if (tmr >= SOFT_CYC - 1) next_st = ST_STEADY;
        ST_STEADY:
        begin
          if (below3_s)
            next_st = ST_RETRY;
          else if (ll_hit)
            next_st = ST_LLOFF;
        end
        ST_RETRY: if (tmr >= RETRY_CYC - 1) next_st = ST_RESTART;
        ST_LLOFF: next_st = ST_LLOFF;
      endcase
  end

  wire logic [2:0] next_code = !active ? `CPOC_CODE_RESTART :
                               (next_st == ST_SOFT) ? `CPOC_CODE_SOFT :
                               (next_st == ST_STEADY) ? `CPOC_CODE_STEADY :
                               (next_st == ST_RETRY) ? `CPOC_CODE_RETRY :
                               (next_st == ST_LLOFF) ? `CPOC_CODE_LLOFF :
                               `CPOC_CODE_RESTART;
  wire logic next_running = active && (next_st == ST_SOFT || next_st == ST_STEADY);

  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      st <= ST_RESTART;
      tmr <= 32'h0;
      ll_cnt <= 32'h0;
      ov_cnt <= 32'h0;
      ov_idle <= 1'b0;
      state_code <= 3'h0;
    end
    else
    begin
      st <= next_st;
      tmr <= (next_st != st) ? 32'h0 : tmr + 32'h1;
      ll_cnt <= ll_cond ? ll_cnt + 32'h1 : 32'h0;
      ov_cnt <= (ov_s && active) ? ov_cnt + 32'h1 : 32'h0;
      ov_idle <= next_ov_idle;
      state_code <= next_code;
    end

  // Frequency is a build-time strap; it reads back and has no write path
  wire logic [7:0] status_byte = {3'h0, FSW_SEL, state_code};
  wire logic [7:0] rd_mux = (reg_addr == `CPOC_OFS_LL_CTRL) ? ll_ctrl :
                            (reg_addr == `CPOC_OFS_OUTPUT_VOLTAGE_TARGET_LO) ? output_voltage_target_target[7:0] :
                            (reg_addr == `CPOC_OFS_OUTPUT_VOLTAGE_TARGET_HI) ? {3'h0, ramp_rate, output_voltage_target_target[10:8]} :
                            (reg_addr == `CPOC_OFS_CONV_CTRL) ? {7'h00, conv_enable} :
                            (reg_addr == `CPOC_OFS_STATUS) ? status_byte :
                            8'h00;

  // Output setpoint ramp and discharge loads
  logic [9:0] ramp_cnt;
  wire logic [9:0] ramp_limit = RAMP_CYC << ramp_rate;
  wire logic ramp_tick = ramp_cnt >= ramp_limit - 10'h1;
  wire logic step_dn = output_voltage_target_setpoint > output_voltage_target_target;
  wire logic step_up = output_voltage_target_setpoint < output_voltage_target_target;
  wire logic next_disch = dndis_en && active && (step_dn || (discharge_load_en && !inreg_s));

  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      ramp_cnt <= 10'h0;
      output_voltage_target_setpoint <= `CPOC_RST_OUTPUT_VOLTAGE_TARGET;
      discharge_load_en <= 1'b0;
      ov_pulldown_en <= 1'b0;
      switch_en <= 1'b0;
      output_on <= 1'b0;
      input_idle_mode <= 1'b0;
      reg_rdata <= 8'h00;
    end
    else
    begin
      ramp_cnt <= (ramp_tick || !(step_dn || step_up)) ? 10'h0 : ramp_cnt + 10'h1;
      if (ramp_tick && step_up)
        output_voltage_target_setpoint <= output_voltage_target_setpoint + 11'h1;
      else if (ramp_tick && step_dn)
        output_voltage_target_setpoint <= output_voltage_target_setpoint - 11'h1;
      discharge_load_en <= next_disch;
      ov_pulldown_en <= ovdis_en && ov_s;
      switch_en <= next_running && !ov_s;
      output_on <= next_running;
      input_idle_mode <= next_ov_idle || (active && next_st == ST_LLOFF);
      if (reg_rd)
        reg_rdata <= rd_mux;
    end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  ll_window_a: assert property ($rose(st == ST_LLOFF) |->
    $past(buck_s) && $past(headroom_s) && $past(below6_s)) else $error("shutdown outside window");
  ll_arm_a: assert property ($rose(st == ST_LLOFF) |-> $past(ll_en))
    else $error("shutdown while disarmed");
  ll_current_a: assert property (ll_cnt != 32'h0 |-> $past(ilow_s))
    else $error("light-load timer ran on high current");
  ll_delay_a: assert property ($rose(st == ST_LLOFF) |-> $past(ll_cnt) >= $past(ll_limit))
    else $error("shutdown before delay");
  ll_off_a: assert property (st == ST_LLOFF && active |-> !output_on && input_idle_mode)
    else $error("output left on in shutdown");
  ll_restart_a: assert property (!ll_cond |=> ll_cnt == 32'h0)
    else $error("light-load timer not cleared");
  code_valid_a: assert property (state_code <= 3'h4)
    else $error("invalid state code");
  idle_code_a: assert property (!active_req |=> state_code == 3'h0)
    else $error("nonzero code outside active mode");
  ramp_step_a: assert property ($changed(output_voltage_target_setpoint) |->
    $past(ramp_tick) && (output_voltage_target_setpoint == $past(output_voltage_target_setpoint) + 11'h1 ||
    output_voltage_target_setpoint == $past(output_voltage_target_setpoint) - 11'h1)) else $error("ramp jumped");
  dn_disch_a: assert property (dndis_en && active && step_dn |=> discharge_load_en)
    else $error("discharge load missing on downstep");
  ov_pull_a: assert property (ovdis_en && ov_s |=> ov_pulldown_en)
    else $error("overvoltage pulldown missing");
  retry_back_a: assert property (active && st == ST_RETRY && tmr == RETRY_CYC - 1 |=>
    st == ST_RESTART) else $error("retry did not restart");
  ov_stop_a: assert property (ov_s |=> !switch_en)
    else $error("switching during overvoltage");
  start_seq_a: assert property (active && st == ST_RESTART |=> st == ST_SOFT)
    else $error("restart did not enter soft start");
  soft_on_a: assert property (st == ST_SOFT |-> output_on)
    else $error("output off in soft start");
  retry_off_a: assert property (st == ST_RETRY |-> !output_on && !switch_en)
    else $error("output on during retry");
  retry_code_a: assert property (st == ST_RETRY |-> state_code == 3'h3)
    else $error("retry state code wrong");
  lloff_code_a: assert property (st == ST_LLOFF |-> state_code == 3'h4)
    else $error("shutdown state code wrong");
  lloff_hold_a: assert property (st == ST_LLOFF && active |=> st == ST_LLOFF)
    else $error("shutdown left while active");
  ov_idle_pin_a: assert property (ov_idle |-> input_idle_mode)
    else $error("overvoltage idle not flagged");
  ov_idle_off_a: assert property (ov_idle |=> state_code == 3'h0 && !output_on)
    else $error("converter running in overvoltage idle");
  freq_read_a: assert property (reg_rd && reg_addr == `CPOC_OFS_STATUS |=>
    reg_rdata[4:3] == FSW_SEL) else $error("frequency code not fixed");
  disch_gate_a: assert property (!dndis_en |=> !discharge_load_en)
    else $error("discharge load on while disabled");
  pull_gate_a: assert property (!ovdis_en |=> !ov_pulldown_en)
    else $error("overvoltage pulldown on while disabled");
  output_voltage_target_write_a: assert property (wr_lo |=> output_voltage_target_target[7:0] == $past(reg_wdata))
    else $error("target low byte not written");
  ll_gate_a: assert property (!ll_window |=> ll_cnt == 32'h0)
    else $error("light-load timer ran outside window");
  ll_disarm_a: assert property (!ll_en |=> ll_cnt == 32'h0)
    else $error("light-load timer ran while disarmed");

  lloff_reach_c: cover property ($rose(st == ST_LLOFF));
  retry_reach_c: cover property (st == ST_RETRY ##1 st == ST_RESTART);
  disch_seen_c: cover property ($fell(discharge_load_en));
  ov_idle_c: cover property ($rose(ov_idle));
  ramp_move_c: cover property ($changed(output_voltage_target_setpoint));
endmodule
`default_nettype wire

// ==== testbench/cpoc_host.sv ====
// Host model: register strobes and enable pin driver
`timescale 1ns/1ns
`default_nettype none
module cpoc_host (
  input wire logic clock,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic en_pin
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    en_pin = 1'b0;
  end
  // One strobe per access; an idle bus shows the inverse so stale values never look live
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic set_en(input logic v);
    @(negedge clock);
    en_pin = v;
  endtask
endmodule
`default_nettype wire

// ==== testbench/cpoc_top_bench.sv ====
// Bench for the converter control block with host model and queued checks
`timescale 1ns/1ns
`default_nettype none
module cpoc_top_bench;
  import cpoc_pkg::*;
  typedef struct {string name; logic [10:0] v;} cpoc_note_type;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic buck_mode = 1'b1, vin_headroom_ok = 1'b1, output_voltage_target_below_6v = 1'b1, iout_low = 1'b1;
  logic output_voltage_target_below_3v = 1'b0, output_voltage_target_overvoltage = 1'b0, output_voltage_target_in_reg = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, en_pin, took_rd = 1'b0;
  logic switch_en, output_on, input_idle_mode, discharge_load_en, ov_pulldown_en;
  cpoc_output_voltage_target_type output_voltage_target_setpoint;
  logic [2:0] state_code;
  logic [10:0] look_val;
  logic [31:0] seed;
  cpoc_note_type notes[$];
  event look_ev;
  int errors = 0, checks = 0, cycles = 0;
  always #10 clock = ~clock;
  cpoc_host host (.clock, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .en_pin);
  cpoc_top #(.LL_STEP_CYC(20), .RETRY_CYC(10), .OV_CYC(8), .SOFT_CYC(5)) dut (.clock, .rstn,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .en_pin, .buck_mode,
    .vin_headroom_ok, .output_voltage_target_below_6v, .iout_low, .output_voltage_target_below_3v, .output_voltage_target_overvoltage,
    .output_voltage_target_in_reg, .switch_en, .output_on, .input_idle_mode, .discharge_load_en,
    .ov_pulldown_en, .output_voltage_target_setpoint, .state_code);
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic print_verdict();
    if (errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input logic [10:0] seen);
    cpoc_note_type e;
    e = notes.pop_front();
    checks++;
    if (seen !== e.v)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", e.name, e.v, seen);
    end
  endtask
  // Read data is sampled a half cycle after the edge that registered it
  always @(posedge clock) took_rd <= reg_rd;
  always @(negedge clock)
  begin
    if (took_rd)
      cmp({3'h0, reg_rdata});
  end
  always @(look_ev) cmp(look_val);
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      print_verdict();
    end
  end
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    notes.push_back('{n, {3'h0, e}});
    host.access(1'b0, a, 8'h00);
    // Let the read watcher pop its note before any later look queues another
    #1;
  endtask
  task automatic look(input logic [10:0] seen, input logic [10:0] e, input string n);
    notes.push_back('{n, e});
    look_val = seen;
    ->look_ev;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.access(1'b1, a, d);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic wait_code(input logic [2:0] c);
    int k;
    k = 0;
    while (state_code !== c && k < 200)
    begin
      @(negedge clock);
      k++;
    end
  endtask
  initial
  begin
    repeat (3) @(posedge clock);
    @(negedge clock);
    rstn = 1'b1;
    rd(8'h20, 8'h10, "status");
    rd(8'h11, 8'h01, "output_voltage_target_hi");
    rd(8'h12, 8'h01, "conv_ctrl");
    seed = xs(32'hBF3A195F);
    wr(8'h40, seed[7:0]);
    wr(8'h20, seed[15:8]);
    rd(8'h40, 8'h00, "unmapped");
    rd(8'h20, 8'h10, "status_ro");
    wr(8'h0E, 8'hE1);
    rd(8'h0E, 8'h01, "ll_ctrl");
    host.set_en(1'b1);
    wait_code(3'h1);
    rd(8'h20, 8'h11, "soft");
    wait_code(3'h2);
    rd(8'h20, 8'h12, "steady");
    cyc(15);
    iout_low = 1'b0;
    cyc(3);
    iout_low = 1'b1;
    cyc(15);
    look({8'h0, state_code}, 11'h2, "ll_restart");
    wait_code(3'h4);
    look({10'h0, input_idle_mode}, 11'h1, "ll_idle");
    look({10'h0, output_on}, 11'h0, "ll_out_off");
    rd(8'h20, 8'h14, "ll_code");
    host.set_en(1'b0);
    cyc(5);
    rd(8'h20, 8'h10, "inactive");
    wr(8'h0E, 8'h18);
    host.set_en(1'b1);
    wait_code(3'h2);
    cyc(40);
    look({8'h0, state_code}, 11'h2, "disarmed");
    output_voltage_target_below_3v = 1'b1;
    wait_code(3'h3);
    output_voltage_target_below_3v = 1'b0;
    look({10'h0, output_on}, 11'h0, "retry_off");
    cyc(7);
    rd(8'h20, 8'h13, "retry_hold");
    wait_code(3'h2);
    look({8'h0, state_code}, 11'h2, "retry_back");
    wr(8'h10, 8'hF0);
    cyc(2);
    look({10'h0, discharge_load_en}, 11'h1, "dn_load");
    cyc(250);
    look(output_voltage_target_setpoint, 11'h1F0, "ramp_dn");
    output_voltage_target_in_reg = 1'b1;
    cyc(5);
    look({10'h0, discharge_load_en}, 11'h0, "load_off");
    wr(8'h11, 8'h09);
    wr(8'h10, 8'hF4);
    cyc(250);
    look({10'h0, output_voltage_target_setpoint == 11'h1F4}, 11'h0, "rate_slow");
    cyc(250);
    look(output_voltage_target_setpoint, 11'h1F4, "ramp_up");
    output_voltage_target_overvoltage = 1'b1;
    cyc(4);
    look({10'h0, ov_pulldown_en}, 11'h1, "ov_pull");
    look({10'h0, switch_en}, 11'h0, "ov_stop");
    cyc(12);
    rd(8'h20, 8'h10, "ov_code");
    look({10'h0, input_idle_mode}, 11'h1, "ov_idle");
    output_voltage_target_overvoltage = 1'b0;
    wr(8'h12, 8'h00);
    rd(8'h12, 8'h00, "conv_off");
    look({10'h0, input_idle_mode}, 11'h0, "ov_idle_clear");
    wr(8'h12, 8'h01);
    wait_code(3'h2);
    look({10'h0, switch_en}, 11'h1, "reg_restart");
    wr(8'h0E, 8'h1D);
    repeat (60)
    begin
      seed = xs(seed);
      buck_mode = seed[0];
      vin_headroom_ok = seed[1];
      // Never all three high, so the window stays shut
      output_voltage_target_below_6v = seed[2] && !(seed[0] && seed[1]);
      iout_low = seed[3];
      cyc(1);
    end
    look({8'h0, state_code}, 11'h2, "ll_window");
    {buck_mode, vin_headroom_ok, output_voltage_target_below_6v} = 3'h7;
    iout_low = 1'b1;
    cyc(45);
    look({8'h0, state_code}, 11'h2, "ll_slow");
    wait_code(3'h4);
    look({8'h0, state_code}, 11'h4, "ll_open");
    print_verdict();
  end
endmodule
`default_nettype wire
